/* File: rtl/ebw_bus_ctrl.v */
// external bus control: ready wait states, bus release to an outside master,
// two-stage sampling of interrupt, branch and boot inputs, idle wake-up.
// assumes all but the interrupt, branch and boot inputs are synchronous to ref_clk; each ref_clk edge stands for
// a falling edge of the output clock.
//
// Functional notes
// - external waits honoured only with software waits active and at least two programmed
// - ready ignored until all programmed software wait states of the cycle elapse
// - ready sampled on output clock falling edge; outside device meets that edge
// - release request sampled on falling edge; grant driven low on falling edge
// - address, space selects and direction float while the bus is granted
// - strobes float while granted and are driven again after request withdrawn
// - micro-state-complete output changes only on falling output clock edges
// - each interrupt input passes a two-flip-flop synchroniser
// - interrupt recognised on high, low, low sample sequence
// - a low interrupt pulse wakes the device from idle states two and three
// - cycle timing derived from the output clock recomputed after reset
// - branch, interrupt and boot mode inputs sampled on falling edges
`include "ebw_defines.vh"
`default_nettype none
module ebw_bus_ctrl #(
  parameter ADDR_W = `EBW_ADDR_W,
  parameter IRQ_N = `EBW_IRQ_N,
  parameter WAIT_W = `EBW_WAIT_W
) (
  input wire ref_clk,
  input wire rst_n,
  input wire cycleStart,
  input wire cycleIsIo,
  input wire cycleIsWrite,
  input wire cycleSpace,
  input wire cycleProgSpace,
  input wire [ADDR_W-1:0] cycleAddr,
  input wire [WAIT_W-1:0] swWaitCount,
  input wire swWaitEnable,
  input wire ready,
  input wire busReleaseReq_n,
  input wire [IRQ_N-1:0] ext_irq_n,
  input wire nmi_n,
  input wire branch_ctrl_in_n,
  input wire boot_space_select,
  input wire low_power_state_two,
  input wire low_power_state_three,
  output wire cycleBusy,
  output reg cycleDone,
  output reg [ADDR_W-1:0] addrOut,
  output wire addrOe,
  output reg program_space_sel_n,
  output reg data_space_sel_n,
  output reg io_space_sel_n,
  output wire spaceSelOe,
  output reg readNotWrite,
  output wire readNotWriteOe,
  output reg memory_strobe_n,
  output reg io_strobe_n,
  output wire strobeOe,
  output reg bus_release_grant_n,
  output reg micro_state_complete_n,
  output reg [IRQ_N-1:0] irqRecognised,
  output reg nmiRecognised,
  output reg branchSampled_n,
  output reg bootModeSampled,
  output reg wakeUp,
  output reg [31:0] resetLowCycles
);
  // ************************************
  // bus cycle state machine
  // ************************************
  localparam ST_IDLE = 4'h1;
  localparam ST_SWAIT = 4'h2;
  localparam ST_HWAIT = 4'h4;
  localparam ST_HOLD = 4'h8;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [WAIT_W-1:0] waitCnt_reg;
  reg [WAIT_W-1:0] waitCnt_next;
  reg hwEnable_reg;
  reg hwEnable_next;
  reg holdReq_reg;
  reg readySample;
  reg drive_reg;

  always @(posedge ref_clk) begin
    // request sampled once per falling output clock edge
    if (!rst_n) begin
      holdReq_reg <= 1'b0;
    end else begin
      holdReq_reg <= ~busReleaseReq_n;
    end
  end

  always @(posedge ref_clk) begin
    // registered: outside device times ready against the clock, not the strobe
    if (!rst_n) begin
      readySample <= 1'b1;
    end else begin
      readySample <= ready;
    end
  end

  always @* begin
    state_next = state_reg;
    waitCnt_next = waitCnt_reg;
    hwEnable_next = hwEnable_reg;
    case (state_reg)
      ST_IDLE: begin
        if (holdReq_reg) begin
          state_next = ST_HOLD;
        end else if (cycleStart) begin
          waitCnt_next = swWaitEnable ? swWaitCount : {WAIT_W{1'b0}};
          hwEnable_next = swWaitEnable && (swWaitCount >= `EBW_MIN_SW_WAITS);
          if (swWaitEnable && swWaitCount != {WAIT_W{1'b0}}) begin
            state_next = ST_SWAIT;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_SWAIT: begin
        // ready is not looked at while software waits remain
        if (waitCnt_reg > {{(WAIT_W-1){1'b0}}, 1'b1}) begin
          waitCnt_next = waitCnt_reg - {{(WAIT_W-1){1'b0}}, 1'b1};
        end else if (hwEnable_reg) begin
          waitCnt_next = {WAIT_W{1'b0}};
          state_next = ST_HWAIT;
        end else begin
          waitCnt_next = {WAIT_W{1'b0}};
          state_next = ST_IDLE;
        end
      end
      ST_HWAIT: begin
        if (readySample) begin
          state_next = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!holdReq_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  wire cycleEnd = (state_reg == ST_IDLE && cycleStart && !holdReq_reg &&
                   !(swWaitEnable && swWaitCount != {WAIT_W{1'b0}})) ||
                  (state_reg == ST_SWAIT && state_next == ST_IDLE) ||
                  (state_reg == ST_HWAIT && readySample);
  assign cycleBusy = (state_reg == ST_SWAIT) || (state_reg == ST_HWAIT);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      waitCnt_reg <= {WAIT_W{1'b0}};
      hwEnable_reg <= 1'b0;
      cycleDone <= 1'b0;
      micro_state_complete_n <= 1'b1;
      bus_release_grant_n <= 1'b1;
      drive_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      waitCnt_reg <= waitCnt_next;
      hwEnable_reg <= hwEnable_next;
      cycleDone <= cycleEnd;
      micro_state_complete_n <= ~cycleEnd;
      bus_release_grant_n <= ~(state_next == ST_HOLD);
      // grant goes high on this edge; drivers return one edge later
      drive_reg <= (state_next != ST_HOLD) && bus_release_grant_n;
    end
  end

  // ************************************
  // bus pins
  // ************************************
  assign addrOe = drive_reg;
  assign spaceSelOe = drive_reg;
  assign readNotWriteOe = drive_reg;
  assign strobeOe = drive_reg;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      addrOut <= {ADDR_W{1'b0}};
      program_space_sel_n <= 1'b1;
      data_space_sel_n <= 1'b1;
      io_space_sel_n <= 1'b1;
      readNotWrite <= 1'b1;
      memory_strobe_n <= 1'b1;
      io_strobe_n <= 1'b1;
    end else begin
      if (state_reg == ST_IDLE && cycleStart && !holdReq_reg) begin
        addrOut <= cycleAddr;
        program_space_sel_n <= ~(cycleSpace & cycleProgSpace & ~cycleIsIo);
        data_space_sel_n <= ~(cycleSpace & ~cycleProgSpace & ~cycleIsIo);
        io_space_sel_n <= ~cycleIsIo;
        readNotWrite <= ~cycleIsWrite;
        memory_strobe_n <= cycleIsIo;
        io_strobe_n <= ~cycleIsIo;
      // a zero-wait cycle ends on its start edge, so cycleDone lifts the strobe
      end else if (cycleEnd || cycleDone || state_reg == ST_HOLD) begin
        memory_strobe_n <= 1'b1;
        io_strobe_n <= 1'b1;
      end
    end
  end

  // ************************************
  // input sampling and interrupts
  // ************************************
  wire [IRQ_N:0] irqPins = {nmi_n, ext_irq_n};
  reg [IRQ_N:0] irqMeta;
  reg [IRQ_N:0] irqSync;
  reg [IRQ_N:0] irqOld;
  reg [IRQ_N:0] irqOlder;
  reg [IRQ_N:0] irqHit;
  reg branchMeta;
  reg bootMeta;

  genvar gi;
  generate
    for (gi = 0; gi <= IRQ_N; gi = gi + 1) begin : gIrq
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          irqMeta[gi] <= 1'b1;
          irqSync[gi] <= 1'b1;
          irqOld[gi] <= 1'b1;
          irqOlder[gi] <= 1'b1;
          irqHit[gi] <= 1'b0;
        end else begin
          irqMeta[gi] <= irqPins[gi];
          irqSync[gi] <= irqMeta[gi];
          irqOld[gi] <= irqSync[gi];
          irqOlder[gi] <= irqOld[gi];
          // first stage may be metastable, so only synchronised samples are compared
          // high then low then low across three samples
          irqHit[gi] <= irqOlder[gi] & ~irqOld[gi] & ~irqSync[gi];
        end
      end
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      irqRecognised <= {IRQ_N{1'b0}};
      nmiRecognised <= 1'b0;
    end else begin
      irqRecognised <= irqHit[IRQ_N-1:0];
      nmiRecognised <= irqHit[IRQ_N];
    end
  end

  // ************************************
  // branch and boot mode sampling
  // ************************************
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      branchMeta <= 1'b1;
      branchSampled_n <= 1'b1;
      bootMeta <= 1'b0;
      bootModeSampled <= 1'b0;
    end else begin
      branchMeta <= branch_ctrl_in_n;
      branchSampled_n <= branchMeta;
      bootMeta <= boot_space_select;
      bootModeSampled <= bootMeta;
    end
  end

  // ************************************
  // idle wake-up
  // ************************************
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wakeUp <= 1'b0;
    end else begin
      // deep idle has no running core clock, so wake on the raw level
      // limitation: any low level seen at an edge wakes, even a short glitch
      wakeUp <= (low_power_state_two | low_power_state_three) & ~(&irqPins);
    end
  end

  // ************************************
  // reset-derived timing
  // ************************************
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      resetLowCycles <= 32'h0;
    end else begin
      // cycle-based timing reloaded after every reset
      resetLowCycles <= `EBW_RESET_LOW_CYC;
    end
  end
endmodule
`default_nettype wire

/* File: pkg/ebw_defines.vh */
// constants for the external bus wait, hold and input sampling block
// assumes one 50 MHz clock that stands for the falling edges of the output clock
`ifndef EBW_DEFINES_VH
`define EBW_DEFINES_VH
`define EBW_MIN_SW_WAITS 3'h2
`define EBW_WAIT_W 3
`define EBW_ADDR_W 16
`define EBW_IRQ_N 4
`define EBW_CLK_PERIOD_NS 20
`define EBW_RESET_LOW_US 50
// least reset hold in cycles, rounded up
`define EBW_RESET_LOW_CYC ((`EBW_RESET_LOW_US * 1000 + `EBW_CLK_PERIOD_NS - 1) / `EBW_CLK_PERIOD_NS)
`endif

/* File: testbench/ebw_bus_ctrl_checker.sv */
// port checks on the bus control block
// bound into each ebw_bus_ctrl; one clock, sync reset
`default_nettype none
module ebw_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cycleStart,
  input wire logic [2:0] swWaitCount,
  input wire logic swWaitEnable,
  input wire logic ready,
  input wire logic busReleaseReq_n,
  input wire logic cycleBusy,
  input wire logic cycleDone,
  input wire logic addrOe,
  input wire logic spaceSelOe,
  input wire logic readNotWriteOe,
  input wire logic strobeOe,
  input wire logic memory_strobe_n,
  input wire logic io_strobe_n,
  input wire logic bus_release_grant_n,
  input wire logic micro_state_complete_n
);
  timeunit 1ns / 1ps;
  logic reqSeen;
  // idle also needs the registered request, as the block takes starts on it
  wire idle = memory_strobe_n && io_strobe_n && !cycleBusy && !cycleDone && reqSeen && bus_release_grant_n;
  wire busOff = !addrOe && !spaceSelOe && !readNotWriteOe && !strobeOe;
  wire busOn = addrOe && spaceSelOe && readNotWriteOe && strobeOe;
  always @(posedge ref_clk) reqSeen <= busReleaseReq_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_fast; cycleStart && idle && ~|swWaitCount |=> cycleDone; endproperty
  a_fast: assert property (p_fast) else $error("zero wait cycle late");
  property p_swIgn; cycleStart && idle && swWaitEnable && swWaitCount == 3'h2 |=> !cycleDone [*2]; endproperty
  a_swIgn: assert property (p_swIgn) else $error("ready seen early");
  property p_rdy; cycleBusy && swWaitEnable && swWaitCount > 3'h1 && !ready |=> ##1 !cycleDone; endproperty
  a_rdy: assert property (p_rdy) else $error("cycle ended while not ready");
  property p_grant; $fell(busReleaseReq_n) && idle && !cycleStart ##1 !busReleaseReq_n [*2] |-> !bus_release_grant_n;
  endproperty
  a_grant: assert property (p_grant) else $error("grant late");
  property p_float; !bus_release_grant_n |-> busOff; endproperty
  a_float: assert property (p_float) else $error("bus driven while granted");
  property p_keep; !bus_release_grant_n && !busReleaseReq_n |=> ##1 !bus_release_grant_n; endproperty
  a_keep: assert property (p_keep) else $error("grant dropped early");
  property p_back; $rose(bus_release_grant_n) |-> !addrOe ##1 busOn; endproperty
  a_back: assert property (p_back) else $error("bus not driven again");
  property p_msc; !micro_state_complete_n |-> cycleDone ##1 micro_state_complete_n; endproperty
  a_msc: assert property (p_msc) else $error("state complete out of step");
endmodule
bind ebw_bus_ctrl ebw_checker i_checker (.*);
`default_nettype wire

/* File: testbench/ebw_ready_model.sv */
// slow memory or i/o device answering with ready
// holds ready low a set number of clocks after a strobe falls
`default_nettype none
module ebw_ready_model (
  input wire logic ref_clk,
  input wire logic memory_strobe_n,
  input wire logic io_strobe_n,
  input wire logic [3:0] stall,
  output logic ready
);
  timeunit 1ns / 1ps;
  int k = 0;
  wire sel = !(memory_strobe_n && io_strobe_n);
  // counted on the clock edge, not the strobe edge
  always @(posedge ref_clk) k <= sel ? k + 1 : 0;
  assign ready = !sel || k >= stall;
endmodule
`default_nettype wire

/* File: testbench/ebw_testbench.sv */
// self-checking bench for ebw_bus_ctrl
// a ready model answers strobes; inputs change at rising edges
`default_nettype none
module testbench;
  timeunit 1ns / 1ps;
  logic ref_clk = 1'h0, rst_n = 1'h0, cycleStart = 1'h0, cycleIsIo = 1'h0, cycleIsWrite = 1'h0, swWaitEnable = 1'h0;
  logic busReleaseReq_n = 1'h1, nmi_n = 1'h1, branch_ctrl_in_n = 1'h1, boot_space_select = 1'h0;
  logic low_power_state_two = 1'h0;
  logic [2:0] swWaitCount = 3'h0;
  logic [3:0] ext_irq_n = 4'hf, stall = 4'h0;
  wire logic ready, cycleBusy, cycleDone, addrOe, spaceSelOe, readNotWriteOe, strobeOe, memory_strobe_n, io_strobe_n;
  wire logic bus_release_grant_n, micro_state_complete_n, nmiRecognised, branchSampled_n, bootModeSampled, wakeUp;
  wire logic [3:0] irqRecognised;
  wire logic [31:0] resetLowCycles;
  wire logic [15:0] addrOut;
  wire logic program_space_sel_n, data_space_sel_n, io_space_sel_n, readNotWrite;
  int bad_count = 0, total_checks = 0, n;
  // expected edges to done, waits, enable, stall, write and io per row
  logic [19:0] rows [7] = '{20'h00100, 20'h11132, 20'h32101, 20'h52133, 20'h65120, 20'h03051, 20'h87110};
  ebw_bus_ctrl i_dut (.*, .cycleSpace(!cycleIsIo), .cycleProgSpace(1'h0), .cycleAddr(16'h1234),
    .low_power_state_three(1'h0));
  ebw_ready_model i_ready (.*);
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #10 ref_clk = ~ref_clk;
  initial begin
    #50us;
    bad_count++;
    end_of_test;
  end
  initial begin
    tick(11);
    check(resetLowCycles, 32'h0);
    @(posedge ref_clk) rst_n <= 1'h1;
    tick(1);
    check({resetLowCycles, bus_release_grant_n, memory_strobe_n, io_strobe_n, addrOe}, {32'h9c4, 4'hf});
    $display("reset test done");
    foreach (rows[r]) begin
      @(posedge ref_clk);
      {swWaitCount, swWaitEnable, stall, cycleIsWrite, cycleIsIo} <= {rows[r][14:12], rows[r][8], rows[r][7:4], rows[r][1:0]};
      cycleStart <= 1'h1;
      @(posedge ref_clk) cycleStart <= 1'h0;
      n = 0;
      #1;
      while (cycleDone !== 1'h1 && n < 20) begin
        tick(1);
        n++;
      end
      check(n, rows[r][19:16]);
      $display("row %0d done", r);
    end
    check({addrOut, program_space_sel_n, data_space_sel_n, io_space_sel_n, readNotWrite}, {16'h1234, 4'hb});
    @(posedge ref_clk) busReleaseReq_n <= 1'h0;
    tick(3);
    check({bus_release_grant_n, addrOe, strobeOe}, 3'h0);
    @(posedge ref_clk) cycleStart <= 1'h1;
    @(posedge ref_clk) cycleStart <= 1'h0;
    tick(6);
    check({bus_release_grant_n, memory_strobe_n, cycleDone}, 3'h2);
    @(posedge ref_clk) busReleaseReq_n <= 1'h1;
    tick(2);
    check({bus_release_grant_n, addrOe}, 2'h2);
    tick(1);
    check({addrOe, spaceSelOe, readNotWriteOe, strobeOe}, 4'hf);
    $display("hold test done");
    @(posedge ref_clk) low_power_state_two <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk) {nmi_n, ext_irq_n} <= ~(5'h1 << i);
      tick(1);
      check(wakeUp, 1'h1);
      n = 0;
      while ({nmiRecognised, irqRecognised} !== 5'h1 << i && n < 8) begin
        tick(1);
        n++;
      end
      check(n < 8, 1'h1);
      @(posedge ref_clk) {nmi_n, ext_irq_n} <= 5'h1f;
      tick(3);
    end
    // a one-clock low never shows high, low, low
    @(posedge ref_clk) nmi_n <= 1'h0;
    @(posedge ref_clk) nmi_n <= 1'h1;
    n = 0;
    repeat (8) begin
      tick(1);
      if (nmiRecognised !== 1'h0) n++;
    end
    check(n, 0);
    $display("interrupt test done");
    @(posedge ref_clk) {branch_ctrl_in_n, boot_space_select} <= 2'h1;
    tick(1);
    check({branchSampled_n, bootModeSampled}, 2'h2);
    tick(1);
    check({branchSampled_n, bootModeSampled}, 2'h1);
    $display("sample test done");
    end_of_test;
  end
endmodule
`default_nettype wire
